// *** logic/elp_pkg.sv ***
// Shared constants and types for the EEPROM load and interrupt pin logic.
// Assumes one core clock and a synchronous active-low reset in every user.
package elp_pkg;

	// Four-level strap codes as resolved by the pad comparator
	localparam logic [1:0] STRAP_LVL_GND_1K  = 2'h0;
	localparam logic [1:0] STRAP_LVL_GND_10K = 2'h1;
	localparam logic [1:0] STRAP_LVL_FLOAT   = 2'h2;
	localparam logic [1:0] STRAP_LVL_VDD_1K  = 2'h3;

	// Cycles the synchronised strap must sit still before it is latched
	localparam int unsigned STRAP_SETTLE_CYC = 4;
	localparam int unsigned STRAP_CNT_W      = 3;

	// Synchroniser depth and idle levels of the pins
	localparam int unsigned SYNC_STAGES   = 2;
	localparam logic        PIN_IDLE_HIGH = 1'b1;

	// Number of interrupt event sources
	localparam int unsigned IRQ_EVENTS = 8;

	// Idle values of the outputs
	localparam logic DONE_N_RST   = 1'b1;
	localparam logic CORE_RST_N_R = 1'b0;

	typedef enum logic [1:0] {
		ROLE_UNKNOWN,
		ROLE_MASTER,
		ROLE_SLAVE,
		ROLE_RESERVED
	} elp_role_e;

	// Request toward the EEPROM read engine
	typedef struct packed {
		logic start;
	} elp_load_req_s;

	// Answer from the EEPROM read engine
	typedef struct packed {
		logic done;
		logic ok;
	} elp_load_rsp_s;

endpackage

// *** logic/elp_sync.sv ***
// Multi-bit two-flop synchroniser for asynchronous pin inputs.
// Assumes bits are independent levels; no word coherence is given.
`timescale 1ns/1ps

module elp_sync #(
	parameter int unsigned WIDTH   = 1,
	parameter logic        RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] stab_q;
	logic [WIDTH-1:0] stab_d;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_comb begin
				meta_d[gi] = async_in[gi];
				stab_d[gi] = meta_q[gi];
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					meta_q[gi] <= RST_VAL;
					stab_q[gi] <= RST_VAL;
				end else begin
					meta_q[gi] <= meta_d[gi];
					stab_q[gi] <= stab_d[gi];
				end
			end
		end
	endgenerate

	assign sync_out = stab_q;

endmodule // elp_sync

// *** logic/elp_pins.sv ***
// Control-pin logic of the management side: strap decode, EEPROM load
// request and done pin, slave-mode hold reset, open-drain interrupt.
// Assumes an EEPROM read engine and an interrupt enable register elsewhere
// on the same clock; pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps

module elp_pins #(
	parameter int unsigned IRQ_N = elp_pkg::IRQ_EVENTS
) (
	// Clock and reset
	input  wire logic                   CORE_CLK_IN,
	input  wire logic                   RST_N_IN,
	// Strap and control pins
	input  wire logic [1:0]             BUS_ROLE_STRAP_IN,
	input  wire logic                   LOAD_REQ_N_IN,
	output logic                        LOAD_DONE_N_OUT,
	// Reserved test inputs
	input  wire logic                   RESERVED_IN_A_IN,
	input  wire logic                   RESERVED_IN_B_IN,
	input  wire logic                   RESERVED_IN_C_IN,
	input  wire logic                   RESERVED_IN_D_IN,
	input  wire logic                   RESERVED_IN_E_IN,
	input  wire logic                   RESERVED_IN_F_IN,
	// Open-drain interrupt pin
	output logic                        IRQ_N_OUT,
	output logic                        IRQ_N_OE_OUT,
	// Interrupt sources and enables from the management registers
	input  wire logic [IRQ_N-1:0]       IRQ_EVENT_IN,
	input  wire logic [IRQ_N-1:0]       IRQ_ENABLE_IN,
	// EEPROM read engine
	output elp_pkg::elp_load_req_s      LOAD_REQ_OUT,
	input  wire elp_pkg::elp_load_rsp_s LOAD_RSP_IN,
	// Core control
	output elp_pkg::elp_role_e          BUS_ROLE_OUT,
	output logic                        CORE_RST_N_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [1:0] strap_sync;
	logic       req_n_sync;

	elp_sync #(
		.WIDTH   (2),
		.RST_VAL (1'b0)
	) u_strap_sync (
		.clk_in   (CORE_CLK_IN),
		.rst_n_in (RST_N_IN),
		.async_in (BUS_ROLE_STRAP_IN),
		.sync_out (strap_sync)
	);

	elp_sync #(
		.WIDTH   (1),
		.RST_VAL (elp_pkg::PIN_IDLE_HIGH)
	) u_req_sync (
		.clk_in   (CORE_CLK_IN),
		.rst_n_in (RST_N_IN),
		.async_in (LOAD_REQ_N_IN),
		.sync_out (req_n_sync)
	);

	// Test inputs are plain inputs with no path into the logic

	////////////////////////////////////////////////////////////////////////
	// Strap capture

	logic [1:0]                      strap_prev_q;
	logic [1:0]                      strap_prev_d;
	logic [elp_pkg::STRAP_CNT_W-1:0] settle_q;
	logic [elp_pkg::STRAP_CNT_W-1:0] settle_d;
	elp_pkg::elp_role_e              role_q;
	elp_pkg::elp_role_e              role_d;

	// Last count of the settle window, cut to the counter width
	localparam logic [elp_pkg::STRAP_CNT_W-1:0] SETTLE_LAST = elp_pkg::STRAP_SETTLE_CYC[elp_pkg::STRAP_CNT_W-1:0];

	always_comb begin
		strap_prev_d = strap_sync;
		settle_d     = settle_q;
		role_d       = role_q;
		if (role_q == elp_pkg::ROLE_UNKNOWN) begin
			if (strap_sync != strap_prev_q) begin
				settle_d = '0;
			end else if (settle_q != SETTLE_LAST) begin
				settle_d = settle_q + 1'b1;
			end else begin
				unique case (strap_sync)
					elp_pkg::STRAP_LVL_FLOAT:  role_d = elp_pkg::ROLE_MASTER;
					elp_pkg::STRAP_LVL_VDD_1K: role_d = elp_pkg::ROLE_SLAVE;
					default:                   role_d = elp_pkg::ROLE_RESERVED;
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			strap_prev_q <= elp_pkg::STRAP_LVL_GND_1K;
			settle_q     <= '0;
			role_q       <= elp_pkg::ROLE_UNKNOWN;
		end else begin
			strap_prev_q <= strap_prev_d;
			settle_q     <= settle_d;
			role_q       <= role_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Load sequencer

	typedef enum logic [2:0] {
		ST_STRAP,
		ST_WAIT_REQ,
		ST_LOADING,
		ST_PASS,
		ST_FAIL,
		ST_SLAVE,
		ST_PARKED
	} elp_load_st_e;

	elp_load_st_e st_q;
	elp_load_st_e st_d;
	logic         start_q;
	logic         start_d;
	logic         done_n_q;
	logic         done_n_d;
	logic         core_rst_n_q;
	logic         core_rst_n_d;

	always_comb begin
		st_d         = st_q;
		start_d      = 1'b0;
		done_n_d     = done_n_q;
		core_rst_n_d = core_rst_n_q;
		unique case (st_q)
			ST_STRAP: begin
				done_n_d     = elp_pkg::DONE_N_RST;
				core_rst_n_d = elp_pkg::CORE_RST_N_R;
				if (role_q == elp_pkg::ROLE_MASTER) begin
					st_d         = ST_WAIT_REQ;
					core_rst_n_d = 1'b1;
				end else if (role_q == elp_pkg::ROLE_SLAVE) begin
					st_d = ST_SLAVE;
				end else if (role_q == elp_pkg::ROLE_RESERVED) begin
					st_d = ST_PARKED;
				end
			end
			ST_WAIT_REQ: begin
				done_n_d = 1'b1;
				if (!req_n_sync) begin
					st_d    = ST_LOADING;
					start_d = 1'b1;
				end
			end
			ST_LOADING: begin
				done_n_d = 1'b1;
				if (LOAD_RSP_IN.done) begin
					st_d     = LOAD_RSP_IN.ok ? ST_PASS : ST_FAIL;
					done_n_d = !LOAD_RSP_IN.ok;
				end
			end
			ST_PASS: begin
				// Terminal: request level no longer matters
				done_n_d = 1'b0;
			end
			ST_FAIL: begin
				done_n_d = 1'b1;
				// Retry only after the pin has been released
				if (req_n_sync) begin
					st_d = ST_WAIT_REQ;
				end
			end
			ST_SLAVE: begin
				done_n_d     = req_n_sync;
				core_rst_n_d = req_n_sync;
			end
			ST_PARKED: begin
				done_n_d     = 1'b1;
				core_rst_n_d = 1'b1;
			end
			default: begin
				st_d = ST_STRAP;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			st_q         <= ST_STRAP;
			start_q      <= 1'b0;
			done_n_q     <= elp_pkg::DONE_N_RST;
			core_rst_n_q <= elp_pkg::CORE_RST_N_R;
		end else begin
			st_q         <= st_d;
			start_q      <= start_d;
			done_n_q     <= done_n_d;
			core_rst_n_q <= core_rst_n_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt pin

	logic irq_oe_q;
	logic irq_oe_d;

	always_comb begin
		irq_oe_d = |(IRQ_EVENT_IN & IRQ_ENABLE_IN);
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			irq_oe_q <= 1'b0;
		end else begin
			irq_oe_q <= irq_oe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign IRQ_N_OUT          = 1'b0;
	assign IRQ_N_OE_OUT       = irq_oe_q;
	assign LOAD_DONE_N_OUT    = done_n_q;
	assign LOAD_REQ_OUT.start = start_q;
	assign BUS_ROLE_OUT       = role_q;
	assign CORE_RST_N_OUT     = core_rst_n_q;

endmodule // elp_pins

// *** sim/elp_pins_chk.sv ***
// Assertions on the pin logic ports.
// Assumes straps move only under reset.
`timescale 1ns/1ps
module elp_pins_chk #(parameter int unsigned IRQ_N = 8) (
	input wire logic CORE_CLK_IN, RST_N_IN, LOAD_REQ_N_IN, LOAD_DONE_N_OUT, IRQ_N_OUT, IRQ_N_OE_OUT, CORE_RST_N_OUT,
	input wire logic [IRQ_N-1:0] IRQ_EVENT_IN, IRQ_ENABLE_IN,
	input wire elp_pkg::elp_load_req_s LOAD_REQ_OUT,
	input wire elp_pkg::elp_load_rsp_s LOAD_RSP_IN,
	input wire elp_pkg::elp_role_e BUS_ROLE_OUT
);
	logic m, s, go;
	assign m = BUS_ROLE_OUT == elp_pkg::ROLE_MASTER;
	assign s = BUS_ROLE_OUT == elp_pkg::ROLE_SLAVE;
	assign go = LOAD_REQ_OUT.start;
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	property p_oe; $past(RST_N_IN) |-> IRQ_N_OE_OUT == |$past(IRQ_EVENT_IN & IRQ_ENABLE_IN); endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_od; !IRQ_N_OUT; endproperty
	a_od: assert property (p_od) else $error("od");
	property p_fol; s && $past(s, 5) |-> LOAD_DONE_N_OUT == $past(LOAD_REQ_N_IN, 3) && CORE_RST_N_OUT == LOAD_DONE_N_OUT;
	endproperty
	a_fol: assert property (p_fol) else $error("follow");
	property p_ok; m && LOAD_RSP_IN.done && LOAD_RSP_IN.ok |=> !LOAD_DONE_N_OUT; endproperty
	a_ok: assert property (p_ok) else $error("ok");
	property p_fell; m && $fell(LOAD_DONE_N_OUT) |-> $past(LOAD_RSP_IN.done && LOAD_RSP_IN.ok); endproperty
	a_fell: assert property (p_fell) else $error("fell");
	property p_go; m && $past(m, 3) && LOAD_DONE_N_OUT && $fell(LOAD_REQ_N_IN) |-> ##[3:4] go; endproperty
	a_go: assert property (p_go) else $error("go");
	property p_one; go |=> !go [*8]; endproperty
	a_one: assert property (p_one) else $error("one");
	property p_quiet; !m || !LOAD_DONE_N_OUT |-> !go; endproperty
	a_quiet: assert property (p_quiet) else $error("quiet");
	c_load: cover property (go);
	c_pass: cover property (m && $fell(LOAD_DONE_N_OUT));
	c_irq: cover property ($rose(IRQ_N_OE_OUT));
endmodule // elp_pins_chk
bind elp_pins elp_pins_chk #(.IRQ_N(IRQ_N)) elp_pins_chk_inst (.*);

// *** sim/elp_eeprom_model.sv ***
// EEPROM engine stand-in answering each start.
// Assumes start is a one-cycle pulse.
`timescale 1ns/1ps
module elp_eeprom_model (
	input wire logic clk_in, ok_sel_in,
	input wire elp_pkg::elp_load_req_s req_in,
	output elp_pkg::elp_load_rsp_s rsp_out
);
	int cnt = -1;
	elp_pkg::elp_load_rsp_s rsp_q = '0;
	always @(posedge clk_in) begin
		// Status is junk outside done
		if (!req_in.start && cnt == 0)
			rsp_q <= '{1'b1, ok_sel_in};
		else
			rsp_q <= '{1'b0, ~rsp_q.ok};
		if (req_in.start)
			cnt <= ok_sel_in ? 9 : 1;
		else if (cnt >= 0)
			cnt <= cnt - 1;
	end
	assign rsp_out = rsp_q;
endmodule // elp_eeprom_model

// *** sim/elp_tb.sv ***
// Bench: master load, interrupt, slave follow.
// Assumes the package and the engine model.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, rst_n = 1'b0, req_n = 1'b1, ok_sel = 1'b0, done_n, IRQ_N_OUT, IRQ_N_OE_OUT, CORE_RST_N_OUT, e;
	logic [5:0] res = 6'h00;
	logic [7:0] IRQ_EVENT_IN = 8'h00, IRQ_ENABLE_IN = 8'h00;
	logic [31:0] seed = 32'h8E01AF98;
	logic [1:0] BUS_ROLE_STRAP_IN = 2'h2;
	elp_pkg::elp_load_req_s LOAD_REQ_OUT;
	elp_pkg::elp_load_rsp_s LOAD_RSP_IN;
	elp_pkg::elp_role_e BUS_ROLE_OUT;
	int fails = 0, checks = 0, starts = 0, i;
	logic exp_q[$];
	wire pin = IRQ_N_OE_OUT ? IRQ_N_OUT : 1'b1;
	always #2 clk = ~clk;
	elp_pins elp_pins_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .BUS_ROLE_STRAP_IN(BUS_ROLE_STRAP_IN),
		.LOAD_REQ_N_IN(req_n), .LOAD_DONE_N_OUT(done_n),
		.RESERVED_IN_A_IN(res[0]), .RESERVED_IN_B_IN(res[1]), .RESERVED_IN_C_IN(res[2]),
		.RESERVED_IN_D_IN(res[3]), .RESERVED_IN_E_IN(res[4]), .RESERVED_IN_F_IN(res[5]),
		.IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE_OUT(IRQ_N_OE_OUT), .IRQ_EVENT_IN(IRQ_EVENT_IN),
		.IRQ_ENABLE_IN(IRQ_ENABLE_IN), .LOAD_REQ_OUT(LOAD_REQ_OUT), .LOAD_RSP_IN(LOAD_RSP_IN),
		.BUS_ROLE_OUT(BUS_ROLE_OUT), .CORE_RST_N_OUT(CORE_RST_N_OUT));
	elp_eeprom_model elp_eeprom_model_inst (.clk_in(clk), .ok_sel_in(ok_sel), .req_in(LOAD_REQ_OUT),
		.rsp_out(LOAD_RSP_IN));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(string n, logic x, logic y);
		checks++;
		if (y !== x) begin
			fails++;
			$display("Error %s expected %b seen %b", n, x, y);
		end
	endtask
	task print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task rst(logic [1:0] v);
		@(posedge clk);
		rst_n <= 1'b0;
		BUS_ROLE_STRAP_IN <= v;
		req_n <= 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (14) @(posedge clk);
	endtask
	always @(posedge clk)
		if (LOAD_REQ_OUT.start === 1'b1)
			starts++;
	always @(posedge clk)
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			#1 chk("irq_pin", !e, pin);
		end
	initial begin
		rst(elp_pkg::STRAP_LVL_FLOAT);
		chk("role", 1'b1, BUS_ROLE_OUT === elp_pkg::ROLE_MASTER);
		req_n <= 1'b0;
		repeat (14) @(posedge clk);
		chk("loads", 1'b1, starts == 1);
		chk("fail_done", 1'b1, done_n);
		req_n <= 1'b1;
		ok_sel <= 1'b1;
		repeat (4) @(posedge clk);
		req_n <= 1'b0;
		for (i = 0; i < 40 && done_n !== 1'b0; i++)
			@(posedge clk);
		if (done_n !== 1'b0) begin
			fails++;
			$display("Error load_wait expected 0 seen %b", done_n);
		end
		repeat (30) @(posedge clk);
		chk("ok_done", 1'b0, done_n);
		chk("loads", 1'b1, starts == 2);
		chk("core_rst", 1'b1, CORE_RST_N_OUT);
		$display("master test done");
		repeat (200) begin
			@(posedge clk);
			void'(rnd());
			IRQ_EVENT_IN <= seed[7:0];
			IRQ_ENABLE_IN <= seed[15:8];
			res <= seed[21:16];
			#1 exp_q.push_back(|(IRQ_EVENT_IN & IRQ_ENABLE_IN));
		end
		repeat (3) @(posedge clk);
		$display("irq test done");
		rst(elp_pkg::STRAP_LVL_VDD_1K);
		chk("role", 1'b1, BUS_ROLE_OUT === elp_pkg::ROLE_SLAVE);
		repeat (8) begin
			void'(rnd());
			req_n <= seed[0];
			repeat (5) @(posedge clk);
			chk("follow", seed[0], done_n);
			chk("core_rst", seed[0], CORE_RST_N_OUT);
		end
		chk("loads", 1'b1, starts == 2);
		$display("slave test done");
		rst(elp_pkg::STRAP_LVL_GND_10K);
		chk("role", 1'b1, BUS_ROLE_OUT === elp_pkg::ROLE_RESERVED);
		req_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("loads", 1'b1, starts == 2);
		chk("park_done", 1'b1, done_n);
		$display("reserved test done");
		print_verdict();
	end
endmodule // testbench
